// File: design/biu_pkg.sv
package biu_pkg;
    // Bus widths
    localparam int ADDR_W = 20;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int HI_W = ADDR_W - WORD_W;
    // Prefetch queue sizing
    localparam int QUEUE_BYTES = 6;
    localparam int FETCH_BYTES = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W = 4;
    localparam logic [LVL_W-1:0] FETCH_ROOM = LVL_W'(QUEUE_BYTES - FETCH_BYTES);
    localparam logic [1:0] WORD_BYTES = 2'h2;
    localparam logic [ADDR_W-1:0] FETCH_STEP = 20'h0_0002;
    // Bus cycle states; T1 to T4 take two ref_clk phases each
    typedef enum logic [2:0] {
        TI,
        T1,
        T2,
        T3,
        T4,
        THOLD
    } tstate_t;
    // Bus cycle kinds
    typedef enum logic [1:0] {
        K_FETCH,
        K_READ,
        K_WRITE,
        K_INTERRUPT_ACK_STROBE_N
    } kind_t;
endpackage : biu_pkg

// File: design/min_mode_bus_interface_unit.sv
`timescale 1ns/1ps

// Shift register queue, head always in flip-flops
module prefetch_fifo #(
    parameter int W = 8,
    parameter int D = 8,
    parameter int LW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [LW-1:0] level
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [LW-1:0] level;
        logic out_valid;
        logic in_ready;
    } fifo_state_t;

    localparam fifo_state_t FIFO_RESET = '{mem: '0, level: '0, out_valid: 1'b0, in_ready: 1'b1};

    fifo_state_t r;
    fifo_state_t n;
    logic push;
    logic pop;

    // Next state of the queue
    always_comb begin
        n = r;
        push = in_valid && r.in_ready;
        pop = r.out_valid && out_ready;
        if (pop) begin
            for (int i = 0; i < D - 1; i++) begin
                n.mem[i] = r.mem[i+1];
            end
        end
        // FIFO order: new byte lands behind the newest
        if (push) begin
            if (pop) begin
                n.mem[LW'(r.level - 1'b1)] = in_data;
            end else begin
                n.mem[r.level] = in_data;
            end
        end
        n.level = flush ? '0 : LW'(r.level + LW'(push) - LW'(pop));
        // Empty queue shows a pushed byte on the next cycle
        n.out_valid = n.level != '0;
        n.in_ready = n.level < LW'(D);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= FIFO_RESET;
        end else begin
            r <= n;
        end
    end

    assign in_ready = r.in_ready;
    assign out_valid = r.out_valid;
    assign out_data = r.mem[0];
    assign level = r.level;
endmodule : prefetch_fifo

// What this block does
// - Transceiver enable goes low in every memory, I/O and interrupt acknowledge cycle.
// - Read and acknowledge cycles: enable low from middle of T2 to middle of T4.
// - Write cycles: enable low from start of T2 to middle of T4.
// - Transceiver enable floats while the bus is handed to another master.
// - Hold acknowledge rises in the middle of a clock state.
// - Bus and control outputs float together with the acknowledge rising.
// - Request low drops acknowledge; bus driven again only at the next cycle.
// - Request on an idle bus is granted during the next clock.
// - All state is static flip-flops; a stopped clock loses nothing.
// - The prefetch queue holds at most six instruction bytes.
// - A word fetch starts whenever two or more queue bytes are free.
// - Queue hands bytes to the execution unit first in, first out.
// - A byte fetched into an empty queue is offered on the cycle after it is pushed.
// - Read strobe gives no spurious pulse after a long read and idle clocks.
// - No stray read strobe on the first idle clock after a read.
// - Strobe behaviour is the same whatever bus mode is in use.
module min_mode_bus_interface_unit
    import biu_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Execution unit operand request
    input wire logic op_valid,
    input wire logic op_write,
    input wire logic op_io,
    input wire logic op_interrupt_ack_strobe_n,
    input wire logic [ADDR_W-1:0] op_addr,
    input wire logic [WORD_W-1:0] op_wdata,
    output logic op_done,
    output logic [WORD_W-1:0] op_rdata,
    // Instruction queue to execution unit
    input wire logic flush_valid,
    input wire logic [ADDR_W-1:0] flush_addr,
    output logic queue_valid,
    input wire logic queue_take,
    output logic [BYTE_W-1:0] queue_byte,
    // Multiplexed local bus
    input wire logic [WORD_W-1:0] ad_in,
    output logic [WORD_W-1:0] ad_out,
    output logic ad_oe,
    output logic [HI_W-1:0] addr_high,
    // Bus control
    output logic ale,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic interrupt_ack_strobe_n,
    output logic mem_io,
    output logic dt_r,
    output logic ctl_oe,
    output logic data_transceiver_enable_n,
    output logic den_oe,
    // Hold handshake
    input wire logic bus_hold_request,
    output logic bus_hold_ack
);
    typedef struct packed {
        tstate_t ts;
        logic ph;
        kind_t kind;
        logic io;
        logic is_op;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
        logic [ADDR_W-1:0] fetch_addr;
        logic stale;
        logic drive;
        logic hold_s1;
        logic hold_s2;
        logic [WORD_W-1:0] din_s1;
        logic [WORD_W-1:0] din_s2;
        logic [WORD_W-1:0] staged;
        logic [1:0] stg_n;
        logic hold_ack;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic interrupt_ack_strobe_n_n;
        logic mem_io;
        logic dt_r;
        logic den_n;
        logic ad_oe;
        logic [WORD_W-1:0] ad_out;
        logic op_done;
        logic [WORD_W-1:0] op_rdata;
    } biu_state_t;

    localparam biu_state_t BIU_RESET = '{
        ts: TI,
        kind: K_FETCH,
        rd_n: 1'b1,
        wr_n: 1'b1,
        interrupt_ack_strobe_n_n: 1'b1,
        den_n: 1'b1,
        drive: 1'b1,
        default: '0
    };

    biu_state_t r;
    biu_state_t n;
    logic push_ready;
    logic [LVL_W-1:0] q_level;
    logic room;
    logic rdlike;
    logic t23;

    // Prefetch queue between bus and execution unit
    prefetch_fifo #(
        .W(BYTE_W),
        .D(FIFO_DEPTH),
        .LW(LVL_W)
    ) queue (
        .clk(ref_clk),
        .rst_n(reset_n),
        .flush(flush_valid),
        .in_valid(r.stg_n != 2'h0),
        .in_ready(push_ready),
        .in_data(r.staged[BYTE_W-1:0]),
        .out_valid(queue_valid),
        .out_ready(queue_take),
        .out_data(queue_byte),
        .level(q_level)
    );

    // Queue stays within six bytes, staged bytes counted
    assign room = LVL_W'(q_level + LVL_W'(r.stg_n)) <= FETCH_ROOM;

    // Next state: sequencer, hold handshake, queue fill
    always_comb begin
        n = r;
        n.op_done = 1'b0;
        // Two-stage synchronisers on pin inputs
        n.hold_s1 = bus_hold_request;
        n.hold_s2 = r.hold_s1;
        n.din_s1 = ad_in;
        n.din_s2 = r.din_s1;
        // Staged fetch word drains low byte first
        if (r.stg_n != 2'h0 && push_ready) begin
            n.staged = r.staged >> BYTE_W;
            n.stg_n = r.stg_n - 2'h1;
        end
        n.ph = !r.ph;
        unique case (r.ts)
            TI: begin
                if (!r.ph && r.hold_s2) begin
                    // Grant mid-clock, float at once
                    n.ts = THOLD;
                    n.hold_ack = 1'b1;
                    n.drive = 1'b0;
                end else if (r.ph && op_valid) begin
                    n.ts = T1;
                    n.is_op = 1'b1;
                    n.io = op_io;
                    n.addr = op_addr;
                    n.wdata = op_wdata;
                    n.kind = op_interrupt_ack_strobe_n ? K_INTERRUPT_ACK_STROBE_N : (op_write ? K_WRITE : K_READ);
                end else if (r.ph && room && !flush_valid) begin
                    // Word fetch whenever two bytes are free
                    n.ts = T1;
                    n.is_op = 1'b0;
                    n.io = 1'b0;
                    n.kind = K_FETCH;
                    n.addr = r.fetch_addr;
                end
                if (n.ts == T1) begin
                    // Bus taken back only for a real cycle
                    n.drive = 1'b1;
                end
            end
            T1: n.ts = r.ph ? T2 : T1;
            T2: n.ts = r.ph ? T3 : T2;
            T3: n.ts = r.ph ? T4 : T3;
            T4: begin
                if (r.ph) begin
                    n.ts = TI;
                    if (r.is_op) begin
                        n.op_done = 1'b1;
                        n.op_rdata = r.din_s2;
                    end else if (!r.stale && !flush_valid) begin
                        n.staged = r.din_s2;
                        n.stg_n = WORD_BYTES;
                        n.fetch_addr = r.fetch_addr + FETCH_STEP;
                    end
                    n.stale = 1'b0;
                end
            end
            THOLD: begin
                n.ph = 1'b1;
                if (!r.hold_s2) begin
                    // Acknowledge drops, bus stays floated
                    n.ts = TI;
                    n.ph = 1'b0;
                    n.hold_ack = 1'b0;
                end
            end
        endcase
        // Branch: refill from an even address, drop fetch in flight
        if (flush_valid) begin
            n.fetch_addr = {flush_addr[ADDR_W-1:1], 1'b0};
            n.stg_n = 2'h0;
            n.stale = n.ts != TI && n.kind == K_FETCH && !n.is_op;
        end
        // Strobes and enables from the next state
        rdlike = n.kind != K_WRITE;
        t23 = n.ts == T2 || n.ts == T3;
        n.ale = n.ts == T1;
        // Read strobe only in T2 and T3, high in T4 and idle
        n.rd_n = !(t23 && (n.kind == K_FETCH || n.kind == K_READ));
        n.wr_n = !(t23 && n.kind == K_WRITE);
        n.interrupt_ack_strobe_n_n = !(t23 && n.kind == K_INTERRUPT_ACK_STROBE_N);
        n.mem_io = !n.io && n.kind != K_INTERRUPT_ACK_STROBE_N;
        n.dt_r = n.kind == K_WRITE;
        if (rdlike) begin
            // Middle of T2 to middle of T4
            n.den_n = !((n.ts == T2 && n.ph) || n.ts == T3 || (n.ts == T4 && !n.ph));
        end else begin
            // Start of T2 to middle of T4
            n.den_n = !(t23 || (n.ts == T4 && !n.ph));
        end
        n.ad_oe = n.drive && (n.ts == T1 || (!rdlike && (t23 || n.ts == T4)));
        n.ad_out = n.ts == T1 ? n.addr[WORD_W-1:0] : n.wdata;
    end

    // State register; static flops hold through a stopped clock
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= BIU_RESET;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign op_done = r.op_done;
    assign op_rdata = r.op_rdata;
    assign ad_out = r.ad_out;
    assign ad_oe = r.ad_oe;
    assign addr_high = r.addr[ADDR_W-1:WORD_W];
    assign ale = r.ale;
    assign read_strobe_n = r.rd_n;
    assign write_strobe_n = r.wr_n;
    assign interrupt_ack_strobe_n = r.interrupt_ack_strobe_n_n;
    assign mem_io = r.mem_io;
    assign dt_r = r.dt_r;
    assign ctl_oe = r.drive;
    // Enable floats whenever the bus is given away
    assign data_transceiver_enable_n = r.den_n;
    assign den_oe = r.drive;
    assign bus_hold_ack = r.hold_ack;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    den_read_win_a: assert property (
        $rose(r.ale) && r.kind != K_WRITE |-> r.den_n [*3] ##1 !r.den_n [*4] ##1 r.den_n
    ) else $error("read enable window wrong");
    den_write_win_a: assert property (
        $rose(r.ale) && r.kind == K_WRITE |-> r.den_n [*2] ##1 !r.den_n [*5] ##1 r.den_n
    ) else $error("write enable window wrong");
    den_each_cycle_a: assert property (
        $rose(r.ale) |-> ##[1:4] !r.den_n
    ) else $error("enable missing in cycle");
    den_float_a: assert property (
        r.hold_ack |-> !den_oe
    ) else $error("enable driven in hold");
    hold_mid_a: assert property (
        $rose(r.hold_ack) |-> r.ph && r.ts == THOLD
    ) else $error("acknowledge not mid-clock");
    hold_float_a: assert property (
        $rose(r.hold_ack) |-> !ad_oe && !ctl_oe && !den_oe
    ) else $error("bus not floated with acknowledge");
    hold_release_a: assert property (
        r.hold_ack && !r.hold_s2 |=> !r.hold_ack ##1 !ctl_oe
    ) else $error("acknowledge not dropped or bus driven early");
    idle_grant_a: assert property (
        r.ts == TI && !r.ph && r.hold_s2 |=> r.hold_ack
    ) else $error("idle bus not granted");
    queue_cap_a: assert property (
        LVL_W'(q_level + LVL_W'(r.stg_n)) <= LVL_W'(QUEUE_BYTES)
    ) else $error("queue over six bytes");
    fetch_room_a: assert property (
        $rose(r.ale) && r.kind == K_FETCH |-> $past(room)
    ) else $error("fetch without room");
    no_glitch_a: assert property (
        r.ts == T4 || r.ts == TI |-> r.rd_n
    ) else $error("read strobe outside T2 and T3");
endmodule : min_mode_bus_interface_unit

// File: tb/biu_far_side.sv
`timescale 1ns/1ps

// Memory, I/O and interrupt controller on the local bus
module biu_far_side
    import biu_pkg::*;
#(
    parameter logic [WORD_W-1:0] INTERRUPT_ACK_STROBE_N_VECTOR = 16'h0042
) (
    // Clock
    input wire logic ref_clk,
    // Bus from the unit
    input wire logic [WORD_W-1:0] ad_out,
    input wire logic [HI_W-1:0] addr_high,
    input wire logic ale,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic interrupt_ack_strobe_n,
    input wire logic mem_io,
    input wire logic dt_r,
    // Bus back to the unit
    output logic [WORD_W-1:0] ad_in,
    output logic qualified_read_strobe_n,
    // Observed traffic
    output logic [ADDR_W-1:0] cyc_addr,
    output logic cyc_mem,
    output logic [WORD_W-1:0] wr_data,
    output int cycles
);
    logic prev_ale = 1'b0;
    logic in_read = 1'b0;

    // Memory contents as a fixed pattern of the address
    function automatic logic [WORD_W-1:0] word_at(input logic [ADDR_W-1:0] a);
        return a[WORD_W-1:0] ^ 16'h5a3c;
    endfunction : word_at

    initial begin
        ad_in = 16'h0000;
        cycles = 0;
        cyc_addr = 20'h0_0000;
        cyc_mem = 1'b0;
        wr_data = 16'h0000;
    end

    // Strobe passed only inside read cycles, off in T4
    assign qualified_read_strobe_n = read_strobe_n | !in_read;

    // Address taken by the latch enable, never by the strobe edge
    always @(posedge ref_clk) begin
        prev_ale <= ale;
        if (ale && !prev_ale) begin
            cycles <= cycles + 1;
            cyc_addr <= {addr_high, ad_out};
            cyc_mem <= mem_io;
            in_read <= !dt_r;
        end
        if (!write_strobe_n) begin
            wr_data <= ad_out;
        end
        // Data while strobed, a toggling pattern once released
        if (!read_strobe_n) begin
            ad_in <= word_at(cyc_addr);
        end else if (!interrupt_ack_strobe_n) begin
            ad_in <= INTERRUPT_ACK_STROBE_N_VECTOR;
        end else begin
            ad_in <= ~ad_in;
        end
    end
endmodule : biu_far_side

// File: tb/test_min_mode_bus_interface_unit.sv
`timescale 1ns/1ps

module test_min_mode_bus_interface_unit
    import biu_pkg::*;
;
    localparam logic [WORD_W-1:0] INTERRUPT_ACK_STROBE_N_VEC = 16'h00c4;
    logic ref_clk, reset_n, op_valid, op_write, op_io, op_interrupt_ack_strobe_n, op_done, flush_valid;
    logic queue_valid, queue_take, ad_oe, ale, read_strobe_n, write_strobe_n;
    logic interrupt_ack_strobe_n, mem_io, dt_r, ctl_oe, data_transceiver_enable_n, den_oe;
    logic bus_hold_request, bus_hold_ack, qualified_read_strobe_n, cyc_mem;
    logic [ADDR_W-1:0] op_addr, flush_addr, cyc_addr;
    logic [WORD_W-1:0] op_wdata, op_rdata, ad_in, ad_out, wr_data;
    logic [BYTE_W-1:0] queue_byte;
    logic [HI_W-1:0] addr_high;
    int cycles, errors, checked, ticks;

    min_mode_bus_interface_unit u_dut (.ref_clk, .reset_n, .op_valid, .op_write, .op_io, .op_interrupt_ack_strobe_n,
        .op_addr, .op_wdata, .op_done, .op_rdata, .flush_valid, .flush_addr, .queue_valid,
        .queue_take, .queue_byte, .ad_in, .ad_out, .ad_oe, .addr_high, .ale, .read_strobe_n,
        .write_strobe_n, .interrupt_ack_strobe_n, .mem_io, .dt_r, .ctl_oe,
        .data_transceiver_enable_n, .den_oe, .bus_hold_request, .bus_hold_ack);

    biu_far_side #(.INTERRUPT_ACK_STROBE_N_VECTOR(INTERRUPT_ACK_STROBE_N_VEC)) u_far (.ref_clk, .ad_out, .addr_high, .ale,
        .read_strobe_n, .write_strobe_n, .interrupt_ack_strobe_n, .mem_io, .dt_r, .ad_in,
        .qualified_read_strobe_n, .cyc_addr, .cyc_mem, .wr_data, .cycles);

    // Clock, 50 ns period
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task end_of_test;
        $display("Checks %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Bounded wait at falling edges for a level
    task automatic wait_lvl(ref logic sig, input logic lvl, input string name);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (sig !== lvl && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check_val(name, 32'(lvl), 32'(sig));
    endtask : wait_lvl

    // One operand cycle; enable, strobe and qualified strobe recorded for cycles 0..8 after ale
    task run_op(input logic w, io, ia, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                output logic [8:0] den_p, output logic [8:0] stb_p, output logic [8:0] q_p);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_write <= w;
        op_io <= io;
        op_interrupt_ack_strobe_n <= ia;
        op_addr <= a;
        op_wdata <= d;
        wait_lvl(ale, 1'b1, "op ale");
        for (int i = 0; i < 12 && !done; i++) begin
            if (i < 9) begin
                den_p[i] = data_transceiver_enable_n;
                stb_p[i] = ia ? interrupt_ack_strobe_n : (w ? write_strobe_n : read_strobe_n);
                q_p[i] = qualified_read_strobe_n;
            end
            done = op_done;
            if (!done) @(negedge ref_clk);
        end
        check_val("op done", 32'h0000_0001, 32'(done));
        @(posedge ref_clk);
        op_valid <= 1'b0;
    endtask : run_op

    task take_byte(input int n);
        logic [WORD_W-1:0] w;
        w = u_far.word_at(20'h0_0100 + 20'(n & ~1));
        wait_lvl(queue_valid, 1'b1, "queue valid");
        check_val("queue byte", 32'(n[0] ? w[15:8] : w[7:0]), 32'(queue_byte));
        @(posedge ref_clk);
        queue_take <= 1'b1;
        @(posedge ref_clk);
        queue_take <= 1'b0;
    endtask : take_byte

    // Flush, fill to six bytes, refetch only with two free
    task test_queue;
        int c0;
        @(posedge ref_clk);
        flush_valid <= 1'b1;
        flush_addr <= 20'h0_0101;
        @(posedge ref_clk);
        flush_valid <= 1'b0;
        c0 = cycles;
        wait_lvl(ale, 1'b1, "fetch ale");
        repeat (12) @(negedge ref_clk);
        check_val("first byte", 32'h0000_0001, 32'(queue_valid));
        repeat (100) @(negedge ref_clk);
        check_val("fetches full", 32'(c0 + 3), 32'(cycles));
        take_byte(0);
        repeat (40) @(negedge ref_clk);
        check_val("one free", 32'(c0 + 3), 32'(cycles));
        take_byte(1);
        repeat (40) @(negedge ref_clk);
        check_val("two free", 32'(c0 + 4), 32'(cycles));
        for (int n = 2; n < 6; n++) take_byte(n);
    endtask : test_queue

    // Read, write, I/O and acknowledge cycles
    task test_ops;
        logic [8:0] dp, sp, qp;
        run_op(1'b0, 1'b0, 1'b0, 20'h1_2344, 16'h0000, dp, sp, qp);
        check_val("read den", 32'h0000_0187, 32'(dp));
        check_val("read strobe", 32'h0000_01c3, 32'(sp));
        check_val("read data", 32'(u_far.word_at(20'h1_2344)), 32'(op_rdata));
        check_val("read addr", 32'h0001_2344, 32'(cyc_addr));
        check_val("mem space", 32'h0000_0001, 32'(cyc_mem));
        check_val("read qual", 32'h0000_01c3, 32'(qp));
        run_op(1'b1, 1'b0, 1'b0, 20'h0_0456, 16'hbeef, dp, sp, qp);
        check_val("write den", 32'h0000_0183, 32'(dp));
        check_val("write strobe", 32'h0000_01c3, 32'(sp));
        check_val("write data", 32'h0000_beef, 32'(wr_data));
        check_val("write qual", 32'h0000_01ff, 32'(qp));
        run_op(1'b0, 1'b1, 1'b0, 20'h0_0080, 16'h0000, dp, sp, qp);
        check_val("io den", 32'h0000_0187, 32'(dp));
        check_val("io space", 32'h0000_0000, 32'(cyc_mem));
        run_op(1'b0, 1'b0, 1'b1, 20'h0_0000, 16'h0000, dp, sp, qp);
        check_val("interrupt_ack_strobe_n den", 32'h0000_0187, 32'(dp));
        check_val("interrupt_ack_strobe_n strobe", 32'h0000_01c3, 32'(sp));
        check_val("interrupt_ack_strobe_n data", 32'(INTERRUPT_ACK_STROBE_N_VEC), 32'(op_rdata));
        check_val("interrupt_ack_strobe_n qual", 32'h0000_01ff, 32'(qp));
    endtask : test_ops

    // Grant on idle bus, float, no cycles, release
    task test_hold;
        int c0;
        @(posedge ref_clk);
        bus_hold_request <= 1'b1;
        c0 = cycles;
        repeat (5) @(negedge ref_clk);
        check_val("hold ack", 32'h0000_0001, 32'(bus_hold_ack));
        check_val("floated", 32'h0000_0000, 32'({ad_oe, ctl_oe, den_oe}));
        take_byte(6);
        take_byte(7);
        repeat (20) @(negedge ref_clk);
        check_val("no cycle held", 32'(c0), 32'(cycles));
        @(posedge ref_clk);
        bus_hold_request <= 1'b0;
        wait_lvl(bus_hold_ack, 1'b0, "hold drop");
        check_val("still floated", 32'h0000_0000, 32'(ctl_oe));
        wait_lvl(ale, 1'b1, "resume ale");
        check_val("driven again", 32'h0000_0001, 32'(ctl_oe));
    endtask : test_hold

    // Cut a hang short
    always @(posedge ref_clk) begin
        ticks++;
        if (ticks == 20000) begin
            errors++;
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        {reset_n, op_valid, op_write, op_io, op_interrupt_ack_strobe_n, flush_valid, queue_take} = 7'h00;
        bus_hold_request = 1'b0;
        op_addr = 20'h0_0000;
        flush_addr = 20'h0_0000;
        op_wdata = 16'h0000;
        @(negedge ref_clk);
        check_val("reset outputs", 32'h0000_008c, 32'({data_transceiver_enable_n, bus_hold_ack, ale,
            ad_oe, ctl_oe, den_oe, queue_valid, op_done}));
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (100) @(posedge ref_clk);
        test_queue();
        repeat (100) @(posedge ref_clk);
        test_ops();
        test_hold();
        end_of_test();
    end
endmodule : test_min_mode_bus_interface_unit
